// [core/right_channel_offset_monitor_regs.sv]
// Register slice reporting the right channel loop offset monitors.
// Overview of operation
// [RULE_01] The differential offset is a read-only 9-bit code, sign in 0x58 bit 0, low byte in 0x59.
// [RULE_02] The common-mode feedback offset is a read-only 9-bit code, top bit in 0x5C bit 0, low byte in 0x5D.
// [RULE_03] The differential code is two's complement at 0.25 mV a step, from -64.0 mV to +63.75 mV.
// [RULE_04] The common-mode code uses the same signed scale, so all ones reads as -0.25 mV.
// [RULE_05] Spare bytes 0x56, 0x57, 0x5A, 0x5B and bits 7-1 of 0x58 and 0x5C are read/write, reset to zero.
// [RULE_06] Writes leave the monitor fields unchanged while read/write spare fields store what is written.
`timescale 1ns/1ps
module right_channel_offset_monitor_regs
    import offset_monitor_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic differential_offset_offset_load,
    input wire logic [MON_W-1:0] differential_offset,
    input wire logic common_mode_feedback_offset_offset_load,
    input wire logic [MON_W-1:0] common_mode_feedback_offset
);

    // Returns true when the access address selects the given register.
    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        addr_hit = (addr == target);
    endfunction : addr_hit

    logic [DATA_W-1:0] spare_value [NUM_SPARE];
    logic [UPPER_W-1:0] differential_offset_upper;
    logic [UPPER_W-1:0] common_mode_feedback_offset_upper;
    logic [MON_W-1:0] differential_offset_code;
    logic [MON_W-1:0] common_mode_feedback_offset_code;
    logic [DATA_W-1:0] differential_offset_low;
    logic [DATA_W-1:0] common_mode_feedback_offset_low;
    logic differential_offset_sign;
    logic common_mode_feedback_offset_sign;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic rvalid_reg;

    // [RULE_06] Differential code holding register.
    offset_code_hold differential_offset_hold (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(differential_offset_offset_load),
        .code_in(differential_offset),
        .code_out(differential_offset_code),
        .low_byte(differential_offset_low),
        .sign_bit(differential_offset_sign)
    );

    // [RULE_06] Common-mode code holding register.
    offset_code_hold common_mode_feedback_offset_hold (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(common_mode_feedback_offset_offset_load),
        .code_in(common_mode_feedback_offset),
        .code_out(common_mode_feedback_offset_code),
        .low_byte(common_mode_feedback_offset_low),
        .sign_bit(common_mode_feedback_offset_sign)
    );

    // [RULE_05] Spare byte storage.
    generate
        for (genvar i = 0; i < NUM_SPARE; i++) begin : g_spare
            spare_field_cell #(
                .WIDTH(DATA_W)
            ) spare_cell (
                .sys_clk(sys_clk),
                .rst(rst),
                .wr_en(reg_wr && addr_hit(reg_addr, SPARE_ADDRS[i])),
                .wr_data(reg_wdata),
                .value(spare_value[i])
            );
        end
    endgenerate

    // [RULE_05] Upper spare bits of the differential high register.
    spare_field_cell #(
        .WIDTH(UPPER_W)
    ) differential_offset_upper_cell (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(reg_wr && addr_hit(reg_addr, DIFFERENTIAL_OFFSET_HIGH_ADDR)),
        .wr_data(reg_wdata[UPPER_MSB:UPPER_LSB]),
        .value(differential_offset_upper)
    );

    // [RULE_05] Upper spare bits of the common-mode high register.
    spare_field_cell #(
        .WIDTH(UPPER_W)
    ) common_mode_feedback_offset_upper_cell (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(reg_wr && addr_hit(reg_addr, COMMON_MODE_FEEDBACK_OFFSET_HIGH_ADDR)),
        .wr_data(reg_wdata[UPPER_MSB:UPPER_LSB]),
        .value(common_mode_feedback_offset_upper)
    );

    // Read data selection.
    always_comb begin
        rdata_next = UNMAPPED_DATA;
        case (reg_addr)
            SPARE_BYTE_A_ADDR: begin
                rdata_next = spare_value[0];
            end
            SPARE_BYTE_B_ADDR: begin
                rdata_next = spare_value[1];
            end
            // [RULE_01] Differential sign bit read.
            DIFFERENTIAL_OFFSET_HIGH_ADDR: begin
                rdata_next = {differential_offset_upper, differential_offset_sign};
            end
            // [RULE_01] Differential low byte read.
            DIFFERENTIAL_OFFSET_LOW_ADDR: begin
                rdata_next = differential_offset_low;
            end
            SPARE_BYTE_C_ADDR: begin
                rdata_next = spare_value[2];
            end
            SPARE_BYTE_D_ADDR: begin
                rdata_next = spare_value[3];
            end
            // [RULE_02] Common-mode top bit read.
            COMMON_MODE_FEEDBACK_OFFSET_HIGH_ADDR: begin
                rdata_next = {common_mode_feedback_offset_upper, common_mode_feedback_offset_sign};
            end
            // [RULE_02] Common-mode low byte read.
            COMMON_MODE_FEEDBACK_OFFSET_LOW_ADDR: begin
                rdata_next = common_mode_feedback_offset_low;
            end
            default: begin
                rdata_next = UNMAPPED_DATA;
            end
        endcase
    end

    // Read data is captured on the read strobe and held until the next one.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= UNMAPPED_DATA;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    // Read valid is a one-cycle pulse after each read strobe.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;

    // [RULE_03] [RULE_04] Signed step views.
    logic signed [MON_W-1:0] differential_offset_steps;
    logic signed [MON_W-1:0] common_mode_feedback_offset_steps;
    assign differential_offset_steps = $signed(differential_offset_code);
    assign common_mode_feedback_offset_steps = $signed(common_mode_feedback_offset_code);

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (rst);

    sequence s_read_of(logic [ADDR_W-1:0] target);
        reg_rd && addr_hit(reg_addr, target) && !reg_wr
            && !differential_offset_offset_load && !common_mode_feedback_offset_offset_load;
    endsequence

    sequence s_answer;
        ##1 reg_rvalid;
    endsequence

    // [RULE_01] Differential sign bit mapping.
    a_differential_offset_high_read: assert property ( // [RULE_01]
        s_read_of(DIFFERENTIAL_OFFSET_HIGH_ADDR) |-> s_answer
            ##0 (reg_rdata[MON_MSB_BIT] == $past(differential_offset_code[MON_W-1]))
            && (reg_rdata[UPPER_MSB:UPPER_LSB] == $past(differential_offset_upper)))
        else $error("Differential high register read is wrong.");

    // [RULE_01] Differential low byte mapping.
    a_differential_offset_low_read: assert property ( // [RULE_01]
        s_read_of(DIFFERENTIAL_OFFSET_LOW_ADDR) |=> reg_rvalid
            && reg_rdata == $past(differential_offset_code[DATA_W-1:0]))
        else $error("Differential low register read is wrong.");

    // [RULE_02] Common-mode top bit mapping.
    a_common_mode_feedback_offset_high_read: assert property ( // [RULE_02]
        s_read_of(COMMON_MODE_FEEDBACK_OFFSET_HIGH_ADDR) |-> s_answer
            ##0 (reg_rdata[MON_MSB_BIT] == $past(common_mode_feedback_offset_code[MON_W-1]))
            && (reg_rdata[UPPER_MSB:UPPER_LSB] == $past(common_mode_feedback_offset_upper)))
        else $error("Common-mode high register read is wrong.");

    // [RULE_02] Common-mode low byte mapping.
    a_common_mode_feedback_offset_low_read: assert property ( // [RULE_02]
        s_read_of(COMMON_MODE_FEEDBACK_OFFSET_LOW_ADDR) |=> reg_rvalid
            && reg_rdata == $past(common_mode_feedback_offset_code[DATA_W-1:0]))
        else $error("Common-mode low register read is wrong.");

    // [RULE_03] Loaded code is reported in signed steps within range.
    a_differential_offset_signed_scale: assert property ( // [RULE_03]
        differential_offset_offset_load |=> (differential_offset_code == $past(differential_offset))
            && (int'(differential_offset_steps) * STEP_UV <= MON_MAX_UV)
            && (int'(differential_offset_steps) * STEP_UV >= MON_MIN_UV))
        else $error("Differential code scale is wrong.");

    // [RULE_04] All ones reads back as 0xFF on the low byte and as minus one step.
    a_common_mode_feedback_offset_minus_one: assert property ( // [RULE_04]
        common_mode_feedback_offset_offset_load && common_mode_feedback_offset == MON_MINUS_ONE
            ##1 !common_mode_feedback_offset_offset_load [*3]
            ##1 s_read_of(COMMON_MODE_FEEDBACK_OFFSET_LOW_ADDR) |=> reg_rdata == 8'hFF
            && int'(common_mode_feedback_offset_steps) * STEP_UV == -STEP_UV)
        else $error("Common-mode minus one step is wrong.");

    // [RULE_05] Spare byte stores the written value.
    a_spare_store: assert property ( // [RULE_05]
        reg_wr && addr_hit(reg_addr, SPARE_BYTE_C_ADDR)
            ##1 !reg_wr ##1 s_read_of(SPARE_BYTE_C_ADDR)
            |=> reg_rdata == $past(reg_wdata, 3))
        else $error("Spare byte did not store the write.");

    // [RULE_05] Spare fields come out of reset at zero.
    a_spare_reset: assert property ( // [RULE_05]
        @(posedge sys_clk) disable iff (1'b0)
        rst |=> spare_value[0] == RESET_BYTE
            && spare_value[3] == RESET_BYTE
            && differential_offset_upper == RESET_BYTE[UPPER_W-1:0]
            && common_mode_feedback_offset_upper == RESET_BYTE[UPPER_W-1:0])
        else $error("Spare fields not zero after reset.");

    // [RULE_06] A write does not disturb the monitor codes.
    a_monitor_readonly: assert property ( // [RULE_06]
        reg_wr && !differential_offset_offset_load && !common_mode_feedback_offset_offset_load
            |=> $stable(differential_offset_code) && $stable(common_mode_feedback_offset_code))
        else $error("A write changed a monitor code.");

    // [RULE_06] A write to a high register updates only its upper bits.
    a_high_write_split: assert property ( // [RULE_06]
        reg_wr && addr_hit(reg_addr, DIFFERENTIAL_OFFSET_HIGH_ADDR) && !differential_offset_offset_load
            |=> differential_offset_upper == $past(reg_wdata[UPPER_MSB:UPPER_LSB])
            && differential_offset_sign == $past(differential_offset_sign))
        else $error("High register write split is wrong.");

    // Unmapped addresses answer with zero.
    a_unmapped_zero: assert property (
        reg_rd && reg_addr < SPARE_BYTE_A_ADDR |=> reg_rdata == UNMAPPED_DATA)
        else $error("Unmapped read did not return zero.");

    // [RULE_01] Monitor codes come out of reset at zero.
    a_code_reset: assert property ( // [RULE_01]
        @(posedge sys_clk) disable iff (1'b0)
        rst |=> differential_offset_code == MON_RESET && common_mode_feedback_offset_code == MON_RESET)
        else $error("Monitor codes not zero after reset.");

    // [RULE_04] Common-mode load takes the presented code.
    a_common_mode_feedback_offset_load: assert property ( // [RULE_04]
        common_mode_feedback_offset_offset_load |=> common_mode_feedback_offset_code == $past(common_mode_feedback_offset))
        else $error("Common-mode code load is wrong.");

    // [RULE_06] A write to the common-mode high register splits too.
    a_common_mode_feedback_offset_high_split: assert property ( // [RULE_06]
        reg_wr && addr_hit(reg_addr, COMMON_MODE_FEEDBACK_OFFSET_HIGH_ADDR) && !common_mode_feedback_offset_offset_load
            |=> common_mode_feedback_offset_upper == $past(reg_wdata[UPPER_MSB:UPPER_LSB])
            && common_mode_feedback_offset_sign == $past(common_mode_feedback_offset_sign))
        else $error("Common-mode high write split is wrong.");

    // [RULE_06] Writes to the low registers leave the codes alone.
    a_low_write_ignored: assert property ( // [RULE_06]
        reg_wr && (addr_hit(reg_addr, DIFFERENTIAL_OFFSET_LOW_ADDR)
            || addr_hit(reg_addr, COMMON_MODE_FEEDBACK_OFFSET_LOW_ADDR))
            && !differential_offset_offset_load && !common_mode_feedback_offset_offset_load
            |=> $stable(differential_offset_low) && $stable(common_mode_feedback_offset_low))
        else $error("A low register write changed a code.");

    // Read valid follows the read strobe by one cycle.
    a_rvalid_follows: assert property (
        reg_rd |=> reg_rvalid)
        else $error("Read valid did not follow the strobe.");

    // Read valid never stands without a strobe.
    a_rvalid_single: assert property (
        !reg_rd |=> !reg_rvalid)
        else $error("Read valid without a read strobe.");

    // Read data holds between read strobes.
    a_rdata_hold: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("Read data changed without a read.");

endmodule : right_channel_offset_monitor_regs

// [core/offset_monitor_pkg.sv]
// Constants for the right-channel offset monitor register slice.
package offset_monitor_pkg;

    // Register port widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MON_W = 9;
    localparam int UPPER_W = 7;
    localparam int NUM_SPARE = 4;

    // Register offsets.
    localparam logic [7:0] SPARE_BYTE_A_ADDR = 8'h56;
    localparam logic [7:0] SPARE_BYTE_B_ADDR = 8'h57;
    localparam logic [7:0] DIFFERENTIAL_OFFSET_HIGH_ADDR = 8'h58;
    localparam logic [7:0] DIFFERENTIAL_OFFSET_LOW_ADDR = 8'h59;
    localparam logic [7:0] SPARE_BYTE_C_ADDR = 8'h5A;
    localparam logic [7:0] SPARE_BYTE_D_ADDR = 8'h5B;
    localparam logic [7:0] COMMON_MODE_FEEDBACK_OFFSET_HIGH_ADDR = 8'h5C;
    localparam logic [7:0] COMMON_MODE_FEEDBACK_OFFSET_LOW_ADDR = 8'h5D;

    // Spare byte offsets in generate order, entry 0 last.
    localparam logic [NUM_SPARE-1:0][7:0] SPARE_ADDRS = {
        SPARE_BYTE_D_ADDR, SPARE_BYTE_C_ADDR,
        SPARE_BYTE_B_ADDR, SPARE_BYTE_A_ADDR};

    // Field positions.
    localparam int MON_MSB_BIT = 0;
    localparam int UPPER_LSB = 1;
    localparam int UPPER_MSB = 7;

    // Reset values.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [8:0] MON_RESET = 9'h000;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // Monitor code scale: 250 uV per code, two's complement.
    localparam int STEP_UV = 250;
    localparam logic [8:0] MON_MAX_CODE = 9'h0FF;
    localparam logic [8:0] MON_MIN_CODE = 9'h100;
    localparam logic [8:0] MON_MINUS_ONE = 9'h1FF;
    localparam int MON_MAX_UV = 63750;
    localparam int MON_MIN_UV = -64000;

endpackage : offset_monitor_pkg

// [core/offset_code_hold.sv]
// Holding register for one 9-bit signed offset monitor code.
`timescale 1ns/1ps
module offset_code_hold
    import offset_monitor_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [MON_W-1:0] code_in,
    output logic [MON_W-1:0] code_out,
    output logic [DATA_W-1:0] low_byte,
    output logic sign_bit
);

    logic [MON_W-1:0] code_reg;

    // The code changes only on the estimator strobe or on reset, never on a write.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            code_reg <= MON_RESET;
        end else if (load) begin
            code_reg <= code_in;
        end
    end

    assign code_out = code_reg;
    assign low_byte = code_reg[DATA_W-1:0];
    assign sign_bit = code_reg[MON_W-1];

endmodule : offset_code_hold

// [core/spare_field_cell.sv]
// Read/write storage cell for a spare register field with zero reset.
`timescale 1ns/1ps
module spare_field_cell
    import offset_monitor_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] value_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            value_reg <= RESET_BYTE[WIDTH-1:0];
        end else if (wr_en) begin
            value_reg <= wr_data;
        end
    end

    assign value = value_reg;

endmodule : spare_field_cell

// [verification/tb.sv]
// Self-checking testbench for the right-channel offset monitor slice.
`timescale 1ns/1ps
module tb;
    import offset_monitor_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rvalid;
    logic differential_offset_offset_load = 1'b0;
    logic [MON_W-1:0] differential_offset = 9'h000;
    logic common_mode_feedback_offset_offset_load = 1'b0;
    logic [MON_W-1:0] common_mode_feedback_offset = 9'h000;
    int err_count = 0;
    int num_checks = 0;
    int mem [256];
    logic [8:0] differential_offset_m = 9'h000;
    logic [8:0] common_mode_feedback_offset_m = 9'h000;
    logic [7:0] rd_data;
    int uv_list [5] = '{63750, -64000, -250, 0, 250};

    always #25 sys_clk = ~sys_clk;

    right_channel_offset_monitor_regs i_right_channel_offset_monitor_regs (
        .sys_clk(sys_clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .differential_offset_offset_load(differential_offset_offset_load),
        .differential_offset(differential_offset),
        .common_mode_feedback_offset_offset_load(common_mode_feedback_offset_offset_load),
        .common_mode_feedback_offset(common_mode_feedback_offset)
    );

    // The model returns what a read of each address should give.
    function automatic logic [7:0] model_byte(input int a);
        case (a)
            8'h56, 8'h57, 8'h5A, 8'h5B: return 8'(mem[a]);
            8'h58: return {mem[a][7:1], differential_offset_m[8]};
            8'h59: return differential_offset_m[7:0];
            8'h5C: return {mem[a][7:1], common_mode_feedback_offset_m[8]};
            8'h5D: return common_mode_feedback_offset_m[7:0];
            default: return 8'h00;
        endcase
    endfunction : model_byte

    function automatic void model_wr(input int a, input logic [7:0] d);
        if (a inside {8'h56, 8'h57, 8'h58, 8'h5A, 8'h5B, 8'h5C}) begin
            mem[a] = int'(d);
        end
    endfunction : model_wr

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: byte %h not %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_code(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: code %h not %h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: valid %b not %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        model_wr(a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        #1;
        chk_flag(reg_rvalid, 1'b0);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_data = reg_rdata;
        chk_flag(reg_rvalid, 1'b1);
        chk_byte(reg_rdata, model_byte(a));
    endtask : rd

    task automatic load(input logic sel, input logic [8:0] v);
        @(posedge sys_clk);
        differential_offset <= sel ? v : 9'($urandom);
        common_mode_feedback_offset <= sel ? 9'($urandom) : v;
        differential_offset_offset_load <= sel;
        common_mode_feedback_offset_offset_load <= !sel;
        @(posedge sys_clk);
        differential_offset_offset_load <= 1'b0;
        common_mode_feedback_offset_offset_load <= 1'b0;
        if (sel) differential_offset_m = v;
        else common_mode_feedback_offset_m = v;
    endtask : load

    task automatic read_code(input logic sel, input int uv);
        logic [7:0] hi;
        rd(sel ? DIFFERENTIAL_OFFSET_HIGH_ADDR : COMMON_MODE_FEEDBACK_OFFSET_HIGH_ADDR);
        hi = rd_data;
        rd(sel ? DIFFERENTIAL_OFFSET_LOW_ADDR : COMMON_MODE_FEEDBACK_OFFSET_LOW_ADDR);
        chk_code({hi[0], rd_data}, 9'(uv / 250));
    endtask : read_code

    initial begin
        #(50 * 20000);
        err_count++;
        $display("wrong value at %0t: run timed out", $time);
        finish_test;
    end

    initial begin
        void'($urandom(32'h4AD5A8A9));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 8'h56; a <= 8'h5E; a++) rd(8'(a));
        for (int a = 8'h56; a <= 8'h5D; a++) wr(8'(a), 8'($urandom));
        for (int a = 8'h56; a <= 8'h5D; a++) rd(8'(a));
        wr(8'h60, 8'hFF);
        rd(8'h60);
        wr(SPARE_BYTE_C_ADDR, 8'($urandom));
        rd(SPARE_BYTE_C_ADDR);
        foreach (uv_list[i]) begin
            load(1'b1, 9'(uv_list[i] / 250));
            read_code(1'b1, uv_list[i]);
            load(1'b0, 9'(uv_list[i] / 250));
            read_code(1'b0, uv_list[i]);
        end
        repeat (40) begin
            load(1'($urandom), 9'($urandom));
            wr(8'(8'h56 + $urandom_range(7)), 8'($urandom));
            rd(8'(8'h50 + $urandom_range(15)));
        end
        @(posedge sys_clk);
        reg_addr <= SPARE_BYTE_A_ADDR;
        reg_wdata <= 8'h3C;
        reg_wr <= 1'b1;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        chk_byte(reg_rdata, model_byte(SPARE_BYTE_A_ADDR));
        model_wr(SPARE_BYTE_A_ADDR, 8'h3C);
        rd(SPARE_BYTE_A_ADDR);
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        foreach (mem[i]) mem[i] = 0;
        differential_offset_m = 9'h000;
        common_mode_feedback_offset_m = 9'h000;
        for (int a = 8'h56; a <= 8'h5D; a++) rd(8'(a));
        finish_test;
    end
endmodule : tb
